/* File: piamp_pkg.sv */
package piamp_pkg;
  // serial frame layout
  localparam int WORD_BITS = 16;
  localparam int PAIR_BITS = 2 * WORD_BITS;
  localparam int SLOT_BITS = 5;
  localparam logic [4:0] SLOTS_PER_FRAME = 5'h1f;
  localparam logic [4:0] BIT_RESET = 5'h1f;
  localparam logic [4:0] PCM_RX_PUBLISH_BIT = 5'h10;
  localparam logic [4:0] I2S_RX_PUBLISH_BIT = 5'h00;
  localparam logic [4:0] FRAME_START_BIT = 5'h00;

  // audio mode select
  typedef enum logic {
    PIAMP_MODE_PCM = 1'b0,
    PIAMP_MODE_I2S = 1'b1
  } piamp_mode_e;

  // link reference clock and bit clock ceiling
  localparam longint LINK_CLK_PERIOD_PS = 64'd32000;
  localparam longint BCLK_MAX_HZ = 64'd512000;
  localparam longint PS_PER_S = 64'd1000000000000;
  // half bit-clock period in link cycles; rounded up so the rate never
  // goes above the ceiling
  localparam longint BCLK_HALF_DIV = 2 * BCLK_MAX_HZ * LINK_CLK_PERIOD_PS;
  localparam logic [7:0] BCLK_HALF_CYC =
    8'((PS_PER_S + BCLK_HALF_DIV - 64'd1) / BCLK_HALF_DIV);
  localparam logic [7:0] DIV_RESET = 8'h00;

  localparam logic [PAIR_BITS-1:0] PAIR_RESET = 32'h0000_0000;
  localparam int BUF_DEPTH = 2;
endpackage

/* File: piamp_buf.sv */
`timescale 1ns/1ps
module piamp_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] ent_reg [DEPTH];
  logic [WIDTH-1:0] ent_next [DEPTH];
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] wr_idx;
  logic rdy_reg;
  logic vld_reg;

  wire push = i_valid & rdy_reg;
  wire pop = vld_reg & i_ready;

  assign wr_idx = cnt_reg - CW'(pop);
  assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
  assign o_ready = rdy_reg;
  assign o_valid = vld_reg;
  assign o_data = ent_reg[0];

  // head always sits in entry 0 so the read data come from a register
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      ent_next[i] = ent_reg[i];
      if (pop && (i + 1 < DEPTH)) begin
        ent_next[i] = ent_reg[(i + 1) % DEPTH];
      end
      if (push && (CW'(i) == wr_idx)) begin
        ent_next[i] = i_data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
      vld_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != CW'(DEPTH));
      vld_reg <= (cnt_next != '0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      ent_reg <= ent_next;
    end
  end
endmodule

/* File: piamp_top.sv */
`timescale 1ns/1ps
module piamp_top
  import piamp_pkg::*;
#(
  parameter logic [7:0] BCLK_HALF = piamp_pkg::BCLK_HALF_CYC,
  parameter int DEPTH = piamp_pkg::BUF_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_i2s_mode,
  input wire logic i_tx_valid,
  input wire logic [piamp_pkg::PAIR_BITS-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [piamp_pkg::PAIR_BITS-1:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_rx_overrun,
  input wire logic i_link_clk,
  output logic o_aud_bclk,
  output logic o_channel_select_line,
  output logic o_aud_dout,
  input wire logic i_aud_din
);
  import piamp_pkg::*;

  // ---------------- core domain ----------------
  logic [PAIR_BITS-1:0] tx_hold_reg;
  logic req_tgl_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_seen_reg;
  logic overrun_reg;
  logic txb_vld;
  logic [PAIR_BITS-1:0] txb_data;
  logic rxb_rdy;

  // link-domain registers read by the core
  logic ack_tgl_reg;
  logic rx_tgl_reg;
  logic [PAIR_BITS-1:0] rx_word_reg;

  wire tx_pending = req_tgl_reg ^ ack_s2_reg;
  wire tx_pop = txb_vld & ~tx_pending;
  wire rx_evt = rx_s2_reg ^ rx_seen_reg;

  piamp_buf #(
    .WIDTH(PAIR_BITS),
    .DEPTH(DEPTH)
  ) u_tx_buf (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(i_tx_valid),
    .i_data(i_tx_data),
    .o_ready(o_tx_ready),
    .o_valid(txb_vld),
    .o_data(txb_data),
    .i_ready(~tx_pending)
  );

  // a captured pair stays in rx_word_reg for a whole frame, so it is read
  // here without a copy once the toggle has been seen
  piamp_buf #(
    .WIDTH(PAIR_BITS),
    .DEPTH(DEPTH)
  ) u_rx_buf (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(rx_evt),
    .i_data(rx_word_reg),
    .o_ready(rxb_rdy),
    .o_valid(o_rx_valid),
    .o_data(o_rx_data),
    .i_ready(i_rx_ready)
  );

  assign o_rx_overrun = overrun_reg;

  // link acknowledge toggle, two flops before use
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else if (i_ce) begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // publish toggle from the link; an edge of the synced copy is the event
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (i_ce) begin
      rx_s1_reg <= rx_tgl_reg;
      rx_s2_reg <= rx_s1_reg;
      rx_seen_reg <= rx_s2_reg;
      // the newest pair is the one lost, buffered pairs keep their order
      overrun_reg <= rx_evt & ~rxb_rdy;
    end
  end

  // the hold register changes only once the link has acked the old pair,
  // so the link may read it without a synchroniser of its own
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tx_hold_reg <= PAIR_RESET;
      req_tgl_reg <= 1'b0;
    end else if (i_ce && tx_pop) begin
      tx_hold_reg <= txb_data;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ---------------- link domain ----------------
  logic lrst_s1_reg;
  logic lrst_s2_reg;
  logic ce_s1_reg;
  logic ce_s2_reg;
  logic mode_s1_reg;
  logic mode_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic din_s1_reg;
  logic din_s2_reg;
  logic [7:0] div_reg;
  logic bclk_reg;
  logic [SLOT_BITS-1:0] bit_reg;
  logic i2s_reg;
  logic started_reg;
  logic armed_reg;
  logic [PAIR_BITS-1:0] cur_reg;
  logic last_lsb_reg;
  logic dout_reg;
  logic sync_reg;
  logic [PAIR_BITS-1:0] rx_sh_reg;

  // bit clock divided from the link clock
  wire tick = (div_reg == BCLK_HALF - 8'h01);
  wire rise = tick & ~bclk_reg;
  wire fall = tick & bclk_reg;
  wire [SLOT_BITS-1:0] nxt_bit = bit_reg + 5'h01;
  // 32 slots per frame, so frames come at bit clock / 32
  wire frame_start = rise & (nxt_bit == FRAME_START_BIT);
  // mode only switches at a frame boundary
  wire i2s_eff = frame_start ? mode_s2_reg : i2s_reg;
  wire take_new = req_s2_reg ^ ack_tgl_reg;
  // an empty tx path plays silence rather than repeating the old pair
  wire [PAIR_BITS-1:0] word_now =
    frame_start ? (take_new ? tx_hold_reg : PAIR_RESET) : cur_reg;
  wire lsb_now = frame_start ? cur_reg[0] : last_lsb_reg;
  // PCM word sits in the low half, msb first in slots 0..15
  wire pcm_bit = ~nxt_bit[4] & word_now[{1'b0, ~nxt_bit[3:0]}];
  // I2S lags data one slot behind word select; slot 0 ends the right word
  wire i2s_bit = (nxt_bit == FRAME_START_BIT) ? lsb_now :
    word_now[5'(5'h00 - nxt_bit)];
  wire dout_next = i2s_eff ? i2s_bit : pcm_bit;
  // PCM long sync high in first half I2S low=left
  wire sync_next = i2s_eff ? nxt_bit[4] : ~nxt_bit[4];
  wire [PAIR_BITS-1:0] rx_next = {rx_sh_reg[PAIR_BITS-2:0], din_s2_reg};
  wire rx_shift = i2s_reg | ~bit_reg[4];
  wire rx_pub = armed_reg & (i2s_reg ? (bit_reg == I2S_RX_PUBLISH_BIT) :
    (bit_reg == PCM_RX_PUBLISH_BIT));
  wire [PAIR_BITS-1:0] rx_pub_val = i2s_reg ? rx_next :
    {{WORD_BITS{1'b0}}, rx_sh_reg[WORD_BITS-1:0]};

  assign o_aud_bclk = bclk_reg;
  assign o_channel_select_line = sync_reg;
  assign o_aud_dout = dout_reg;

  // reset and enable enter the link domain through two flops each
  always_ff @(posedge i_link_clk) begin
    lrst_s1_reg <= i_rst_n;
    lrst_s2_reg <= lrst_s1_reg;
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      ce_s1_reg <= 1'b0;
      ce_s2_reg <= 1'b0;
    end else begin
      ce_s1_reg <= i_ce;
      ce_s2_reg <= ce_s1_reg;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      mode_s1_reg <= PIAMP_MODE_PCM;
      mode_s2_reg <= PIAMP_MODE_PCM;
    end else if (ce_s2_reg) begin
      mode_s1_reg <= i_i2s_mode;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // request toggle from the core domain
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
    end
  end

  // data in lags two link clocks through these flops; a half bit of at
  // least three link clocks keeps each falling-edge sample in its own slot
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      din_s1_reg <= 1'b0;
      din_s2_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      din_s1_reg <= i_aud_din;
      din_s2_reg <= din_s1_reg;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      div_reg <= DIV_RESET;
      bclk_reg <= 1'b0;
    end else if (ce_s2_reg) begin
      div_reg <= tick ? DIV_RESET : div_reg + 8'h01;
      if (tick) begin
        bclk_reg <= ~bclk_reg;
      end
    end
  end

  // transmit side: everything moves on the rising edge
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      bit_reg <= BIT_RESET;
      dout_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (ce_s2_reg && rise) begin
      bit_reg <= nxt_bit;
      dout_reg <= dout_next;
      sync_reg <= sync_next;
    end
  end

  // frame state is taken at slot 0 only, so a mode change never splits
  // a frame
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      i2s_reg <= PIAMP_MODE_PCM;
      started_reg <= 1'b0;
      armed_reg <= 1'b0;
      cur_reg <= PAIR_RESET;
      last_lsb_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else if (ce_s2_reg && frame_start) begin
      i2s_reg <= mode_s2_reg;
      started_reg <= 1'b1;
      // first frame after reset or a mode switch is not reported
      armed_reg <= started_reg & (mode_s2_reg == i2s_reg);
      cur_reg <= word_now;
      last_lsb_reg <= lsb_now;
      if (take_new) begin
        ack_tgl_reg <= req_s2_reg;
      end
    end
  end

  // receive side samples on the falling edge
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2_reg) begin
      rx_sh_reg <= PAIR_RESET;
      rx_word_reg <= PAIR_RESET;
      rx_tgl_reg <= 1'b0;
    end else if (ce_s2_reg && fall) begin
      if (rx_shift) begin
        rx_sh_reg <= rx_next;
      end
      if (rx_pub) begin
        rx_word_reg <= rx_pub_val;
        rx_tgl_reg <= ~rx_tgl_reg;
      end
    end
  end
endmodule

/* File: piamp_checker.sv */
`timescale 1ns/1ps
module piamp_checker #(
  parameter logic [7:0] BCLK_HALF = 8'h02
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_rx_ready,
  input wire logic o_rx_valid,
  input wire logic [piamp_pkg::PAIR_BITS-1:0] o_rx_data,
  input wire logic o_rx_overrun,
  input wire logic o_aud_bclk,
  input wire logic o_channel_select_line,
  input wire logic o_aud_dout
);
  import piamp_pkg::*;
  logic bclk_reg, sel_reg, seen_b_reg, seen_s_reg;
  logic [7:0] hcnt_reg;
  logic [5:0] rcnt_reg;
  logic [2:0] lrun_reg;
  // the link side leaves reset three link clocks after the core does
  wire lrun = lrun_reg[2];
  wire bchg = o_aud_bclk ^ bclk_reg;
  wire schg = o_channel_select_line ^ sel_reg;
  // first edge after reset has no full period behind it, so it is skipped
  always_ff @(posedge i_link_clk) begin
    lrun_reg <= {lrun_reg[1:0], i_rst_n};
    bclk_reg <= o_aud_bclk;
    sel_reg <= o_channel_select_line;
    hcnt_reg <= bchg ? 8'h00 : hcnt_reg + 8'h01;
    if (bchg && o_aud_bclk) begin
      rcnt_reg <= schg ? 6'h01 : rcnt_reg + 6'h01;
    end
    seen_b_reg <= i_rst_n & (seen_b_reg | bchg);
    seen_s_reg <= i_rst_n & (seen_s_reg | schg);
  end
  bclk_half_a: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n || !lrun)
    bchg && seen_b_reg |-> hcnt_reg == BCLK_HALF - 8'h01)
    else $error("bit clock half period wrong");
  dout_launch_a: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n || !lrun)
    $changed(o_aud_dout) |-> $rose(o_aud_bclk))
    else $error("data changed off a rising clock");
  sync_launch_a: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n || !lrun)
    $changed(o_channel_select_line) |-> $rose(o_aud_bclk))
    else $error("select changed off a rising clock");
  // 32 only across a mode switch, where one frame keeps its level
  half_frame_a: assert property (@(posedge i_link_clk)
    disable iff (!i_rst_n || !lrun)
    schg && seen_s_reg |-> rcnt_reg inside {6'h10, 6'h20})
    else $error("select half frame not 16 bits");
  overrun_pulse_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) o_rx_overrun |=> !o_rx_overrun)
    else $error("overrun longer than one cycle");
  overrun_full_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) o_rx_overrun |-> o_rx_valid)
    else $error("overrun with empty buffer");
  rx_hold_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n)
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("rx pair not held");
  rx_pop_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n) $fell(o_rx_valid) |-> $past(i_rx_ready))
    else $error("rx pair left without a pop");
  cover property (@(posedge i_core_clk) o_rx_overrun);
  cover property (@(posedge i_core_clk) o_rx_valid && i_rx_ready);
  cover property (@(posedge i_link_clk) schg && seen_s_reg);
endmodule

bind piamp_top piamp_checker #(.BCLK_HALF(BCLK_HALF)) u_chk (.i_core_clk,
  .i_rst_n, .i_link_clk, .i_rx_ready, .o_rx_valid, .o_rx_data,
  .o_rx_overrun, .o_aud_bclk, .o_channel_select_line, .o_aud_dout);

/* File: piamp_codec.sv */
`timescale 1ns/1ps
module piamp_codec (
  input wire logic i_bclk,
  input wire logic i_sel,
  input wire logic i_dout,
  input wire logic i_i2s_mode,
  input wire logic [31:0] i_word,
  output logic o_din,
  output logic [15:0] o_cap_pcm,
  output logic [31:0] o_cap_i2s
);
  logic [4:0] slot_reg = 5'h00;
  logic [31:0] sh_reg = 32'h0;
  logic sel_reg = 1'b0;
  wire start = i_i2s_mode ? (sel_reg & ~i_sel) : (~sel_reg & i_sel);
  wire [32:0] cap = {sh_reg, i_dout};
  wire [4:0] nxt = slot_reg + 5'h01;
  initial o_din = 1'b0;
  always @(negedge i_bclk) begin
    sel_reg <= i_sel;
    sh_reg <= cap[31:0];
    slot_reg <= start ? 5'h00 : nxt;
    if (start) begin
      o_cap_pcm <= cap[32:17];
      o_cap_i2s <= cap[31:0];
    end
  end
  // launched at the rise so only a falling-edge sampler sees it settled
  always @(posedge i_bclk) begin
    if (i_i2s_mode) o_din <= i_word[5'h00 - nxt];
    else if (!nxt[4]) o_din <= i_word[4'hf - nxt[3:0]];
    else o_din <= ~o_din;
  end
endmodule

/* File: pcm_i2s_audio_master_port_tb.sv */
`timescale 1ns/1ps
module pcm_i2s_audio_master_port_tb;
  import piamp_pkg::*;
  logic i_core_clk = 1'b0, i_link_clk = 1'b0, i_rst_n = 1'b0;
  logic i_i2s_mode = 1'b0, i_tx_valid = 1'b0, i_rx_ready = 1'b0;
  logic [31:0] i_tx_data = 32'h0, word = 32'h0, rx_last = 32'h0;
  logic o_tx_ready, o_rx_valid, o_rx_overrun, o_aud_bclk;
  logic o_channel_select_line, o_aud_dout, i_aud_din;
  logic [31:0] o_rx_data, cap_i2s;
  logic [15:0] cap_pcm;
  int n_errors = 0, checks = 0, n_ovr = 0, cyc = 0;

  always #4 i_core_clk = ~i_core_clk;
  initial begin
    #3.1;
    forever #16 i_link_clk = ~i_link_clk;
  end

  piamp_top #(.BCLK_HALF(8'h03)) dut (.i_core_clk, .i_rst_n, .i_ce(1'b1),
    .i_i2s_mode, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid,
    .o_rx_data, .i_rx_ready, .o_rx_overrun, .i_link_clk, .o_aud_bclk,
    .o_channel_select_line, .o_aud_dout, .i_aud_din);
  piamp_codec codec (.i_bclk(o_aud_bclk), .i_sel(o_channel_select_line),
    .i_dout(o_aud_dout), .i_i2s_mode(i_i2s_mode), .i_word(word),
    .o_din(i_aud_din), .o_cap_pcm(cap_pcm), .o_cap_i2s(cap_i2s));

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc++;
    if (o_rx_valid === 1'b1 && i_rx_ready) rx_last <= o_rx_data;
    if (o_rx_overrun === 1'b1) n_ovr++;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end

  // one frame is 768 core cycles at this divider; waits cover buffer lag
  task automatic frames(input int n);
    repeat (n * 768) @(negedge i_core_clk);
  endtask

  task automatic pcm_scn();
    i_rx_ready = 1'b1;
    i_tx_valid = 1'b1;
    for (int i = 0; i < 2; i++) begin
      i_tx_data = i ? 32'hffff_0001 : 32'h0000_8000;
      word = i ? 32'h5555_8003 : 32'h0000_7ffc;
      frames(6);
      check("pcm out", {16'h0, cap_pcm}, {16'h0, i_tx_data[15:0]});
      check("pcm in", rx_last, {16'h0, word[15:0]});
    end
  endtask

  task automatic i2s_scn();
    i_i2s_mode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      i_tx_data = i ? 32'h8001_0001 : 32'h7ffe_c3a5;
      word = i ? 32'h0001_8000 : 32'hc3a5_5a3c;
      frames(6);
      check("i2s out", cap_i2s, i_tx_data);
      check("i2s in", rx_last, word);
    end
  endtask

  // receiver stalls; the two-entry buffer holds and the excess is dropped
  task automatic stall_scn();
    i_rx_ready = 1'b0;
    // a fresh word so that the resumed stream must carry new pairs
    word = 32'h1234_abcd;
    n_ovr = 0;
    frames(5);
    check("rx held", {31'h0, o_rx_valid}, 32'h1);
    check("overrun", {31'h0, n_ovr > 0}, 32'h1);
    i_rx_ready = 1'b1;
    frames(2);
    check("rx resumed", rx_last, word);
  endtask

  initial begin
    // the link side sees three of its own rising edges inside reset
    repeat (12) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    pcm_scn();
    i2s_scn();
    stall_scn();
    conclude();
  end
endmodule
